//--- rtl/ivpm_flag.sv
`timescale 1ns/1ns
// sticky pending flag, set on the rising edge of its source
module ivpm_flag #(
  parameter bit USED = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic src,
  input  wire logic clr,
  output logic      flag
);

  logic src_d;
  logic set;

  // unused slots never see a set, so they stay low forever
  assign set = USED && src && !src_d;

  // previous source level for the edge detector
  always_ff @(posedge clk) begin
    if (rst) begin
      src_d <= 1'b0;
    end else begin
      src_d <= src;
    end
  end

  // set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge clk) begin
    if (rst) begin
      flag <= 1'b0;
    end else begin
      flag <= set | (flag & ~clr);
    end
  end

endmodule

//--- rtl/ivpm_pkg.sv
package ivpm_pkg;

  // request map shape
  localparam int          NUM_REQ     = 24;
  localparam int          LEVEL_REGS  = 6;
  localparam logic [15:0] VEC_TOP     = 16'hfffa;

  // request numbers of the wired sources
  localparam logic [4:0]  REQ_EXT4    = 5'h00;
  localparam logic [4:0]  REQ_EXT5    = 5'h01;
  localparam logic [4:0]  REQ_EXT26   = 5'h02;
  localparam logic [4:0]  REQ_EXT37   = 5'h03;
  localparam logic [4:0]  REQ_TMR0_LO = 5'h05;
  localparam logic [4:0]  REQ_TMR0_HI = 5'h06;
  localparam logic [4:0]  REQ_UART_RX = 5'h07;
  localparam logic [4:0]  REQ_UART_TX = 5'h08;
  localparam logic [4:0]  REQ_TMR1_HI = 5'h0e;
  localparam logic [4:0]  REQ_ADC     = 5'h12;
  localparam logic [4:0]  REQ_TBT     = 5'h13;
  localparam logic [4:0]  REQ_WATCH   = 5'h14;
  localparam logic [4:0]  REQ_TMR1_LO = 5'h16;
  localparam logic [4:0]  REQ_FLASH   = 5'h17;

  // one bit per request that has a source behind it
  localparam logic [23:0] REQ_USED    = 24'hdc41ef;

  // register word indices; byte address is four times the index
  localparam logic [9:0]  IDX_STATUS  = 10'h000;
  localparam logic [9:0]  IDX_ENABLE  = 10'h001;
  localparam logic [9:0]  IDX_CLEAR   = 10'h002;
  localparam logic [9:0]  IDX_WINNER  = 10'h003;
  localparam logic [9:0]  IDX_LEVEL0  = 10'h079;
  localparam logic [9:0]  IDX_LEVEL5  = 10'h07e;

  // values after reset
  localparam logic [7:0]  LEVEL_RESET  = 8'hff;
  localparam logic [23:0] ENABLE_RESET = 24'h000000;

  // axi responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // peripheral request lines, one level each, same clock
  typedef struct packed {
    logic ext_ch2;
    logic ext_ch3;
    logic ext_ch4;
    logic ext_ch5;
    logic ext_ch6;
    logic ext_ch7;
    logic tmr0_lo;
    logic tmr0_hi;
    logic tmr1_lo;
    logic tmr1_hi;
    logic uart_rx;
    logic uart_tx;
    logic adc;
    logic tbt;
    logic watch;
    logic flash;
  } ivpm_src_t;

  // winning request offered to the cpu core
  typedef struct packed {
    logic        valid;
    logic [4:0]  num;
    logic [1:0]  level;
    logic [15:0] vec_upper;
    logic [15:0] vec_lower;
  } ivpm_req_t;

endpackage

//--- rtl/ivpm_top.sv
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
// Function
// - ext channel 4 is request 0, vector FFFA/FFFB, request 0 wins ties
// - ext channel 5 is request 1, vector FFF8/FFF9
// - ext channels 2 and 6 share request 2, vector FFF6/FFF7
// - ext channels 3 and 7 share request 3, vector FFF4/FFF5
// - timer 0 lower half is request 5, vector FFF0/FFF1
// - timer 0 upper half is request 6, vector FFEE/FFEF
// - timer 1 upper half is request 14, vector FFDE/FFDF
// - timer 1 lower half is request 22, vector FFCE/FFCF
// - level register 5 at index 007E, read/write, resets to all ones
module ivpm_top (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire ivpm_pkg::ivpm_src_t src,
  input  wire logic                cpu_ack,
  output ivpm_pkg::ivpm_req_t      req,
  output logic                     irq,
  input  wire logic [11:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [11:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);

  logic [23:0]         req_line;
  logic [23:0]         status;
  logic [23:0]         enable;
  logic [23:0]         clr_vec;
  logic [23:0]         sw_clr;
  logic [23:0]         pending;
  logic [7:0]          ilr [ivpm_pkg::LEVEL_REGS];
  logic [1:0]          lvl [ivpm_pkg::NUM_REQ];
  ivpm_pkg::ivpm_req_t next_req;
  logic                aw_held;
  logic                w_held;
  logic [9:0]          aw_idx;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic [31:0]         wr_mask;
  logic                wr_fire;
  logic                wr_hit;
  logic [9:0]          ar_idx;
  logic [31:0]         rd_word;
  logic                rd_hit;

  // source to request routing; merged channels are or-ed together
  always_comb begin
    req_line                        = 24'h000000;
    req_line[ivpm_pkg::REQ_EXT4]    = src.ext_ch4;
    req_line[ivpm_pkg::REQ_EXT5]    = src.ext_ch5;
    req_line[ivpm_pkg::REQ_EXT26]   = src.ext_ch2 | src.ext_ch6;
    req_line[ivpm_pkg::REQ_EXT37]   = src.ext_ch3 | src.ext_ch7;
    req_line[ivpm_pkg::REQ_TMR0_LO] = src.tmr0_lo;
    req_line[ivpm_pkg::REQ_TMR0_HI] = src.tmr0_hi;
    req_line[ivpm_pkg::REQ_TMR1_HI] = src.tmr1_hi;
    req_line[ivpm_pkg::REQ_TMR1_LO] = src.tmr1_lo;
    req_line[ivpm_pkg::REQ_UART_RX] = src.uart_rx;
    req_line[ivpm_pkg::REQ_UART_TX] = src.uart_tx;
    req_line[ivpm_pkg::REQ_ADC]     = src.adc;
    req_line[ivpm_pkg::REQ_TBT]     = src.tbt;
    req_line[ivpm_pkg::REQ_WATCH]   = src.watch;
    req_line[ivpm_pkg::REQ_FLASH]   = src.flash;
  end

  // cleared by software through the clear register or by a cpu take
  always_comb begin
    clr_vec = sw_clr;
    if (cpu_ack && req.valid) begin
      clr_vec[req.num] = 1'b1;
    end
  end

  // one sticky flag per request; unused slots are built dead
  for (genvar n = 0; n < ivpm_pkg::NUM_REQ; n++) begin : g_flag
    ivpm_flag #(
      .USED (ivpm_pkg::REQ_USED[n])
    ) u_flag (
      .clk  (clk),
      .rst  (rst),
      .src  (req_line[n]),
      .clr  (clr_vec[n]),
      .flag (status[n])
    );
    // four two-bit level fields per level register
    assign lvl[n] = ilr[n / 4][2 * (n % 4) +: 2];
  end

  assign pending = status & enable;
  assign irq     = |pending;

  // lowest level value wins; scanning downward lets low numbers win ties
  always_comb begin
    next_req = '0;
    for (int n = ivpm_pkg::NUM_REQ - 1; n >= 0; n--) begin
      if (pending[n] && (!next_req.valid || lvl[n] <= next_req.level)) begin
        next_req.valid = 1'b1;
        next_req.num   = 5'(n);
        next_req.level = lvl[n];
      end
    end
    next_req.vec_upper = ivpm_pkg::VEC_TOP - {10'h000, next_req.num, 1'b0};
    next_req.vec_lower = next_req.vec_upper | 16'h0001;
  end

  // registered so the core sees a stable vector for a whole cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      req <= '0;
    end else begin
      req <= next_req;
    end
  end

  // write channel capture; address and data may arrive in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  // byte lanes that a write may touch; unstrobed lanes keep their value
  assign wr_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}},
                    {8{w_strb[0]}}};

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_idx  <= 10'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_idx  <= s_axi_awaddr[11:2];
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // status and winner are read only; writes to them are decode misses
  assign wr_hit = (aw_idx == ivpm_pkg::IDX_ENABLE) ||
                  (aw_idx == ivpm_pkg::IDX_CLEAR) ||
                  (aw_idx >= ivpm_pkg::IDX_LEVEL0 &&
                   aw_idx <= ivpm_pkg::IDX_LEVEL5);

  // write response holds until the master takes it
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ivpm_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? ivpm_pkg::RESP_OKAY : ivpm_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // clear is write-one-to-clear and lasts only the write cycle
  always_comb begin
    sw_clr = 24'h000000;
    if (wr_fire && aw_idx == ivpm_pkg::IDX_CLEAR) begin
      sw_clr = w_data[23:0] & wr_mask[23:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      enable <= ivpm_pkg::ENABLE_RESET;
    end else if (wr_fire && aw_idx == ivpm_pkg::IDX_ENABLE) begin
      enable <= (enable & ~wr_mask[23:0]) | (w_data[23:0] & wr_mask[23:0]);
    end
  end

  // level registers: eight bits each, only lane 0 carries data
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int k = 0; k < ivpm_pkg::LEVEL_REGS; k++) begin
        ilr[k] <= ivpm_pkg::LEVEL_RESET;
      end
    end else if (wr_fire && w_strb[0]) begin
      for (int k = 0; k < ivpm_pkg::LEVEL_REGS; k++) begin
        if (aw_idx == ivpm_pkg::IDX_LEVEL0 + 10'(k)) begin
          ilr[k] <= w_data[7:0];
        end
      end
    end
  end

  // read decode; clear register reads back as zero
  always_comb begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b1;
    case (ar_idx)
      ivpm_pkg::IDX_STATUS: rd_word = {8'h00, status};
      ivpm_pkg::IDX_ENABLE: rd_word = {8'h00, enable};
      ivpm_pkg::IDX_CLEAR:  rd_word = 32'h00000000;
      ivpm_pkg::IDX_WINNER: rd_word = {24'h000000, req.valid, req.level,
                                       req.num};
      default: begin
        rd_hit = 1'b0;
        for (int k = 0; k < ivpm_pkg::LEVEL_REGS; k++) begin
          if (ar_idx == ivpm_pkg::IDX_LEVEL0 + 10'(k)) begin
            rd_word = {24'h000000, ilr[k]};
            rd_hit  = 1'b1;
          end
        end
      end
    endcase
  end

  assign ar_idx        = s_axi_araddr[11:2];
  assign s_axi_arready = !s_axi_rvalid;

  // one read in flight; data captured at the address handshake
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= ivpm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? ivpm_pkg::RESP_OKAY : ivpm_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks on routing, vectors, arbitration, level reset and the interrupt output
  sequence s_ext4_rise;
    $rose(src.ext_ch4);
  endsequence

  sequence s_ext26_rise;
    $rose(src.ext_ch2 | src.ext_ch6);
  endsequence

  sequence s_ext37_rise;
    $rose(src.ext_ch3 | src.ext_ch7);
  endsequence

  sequence s_win0_cause;
    pending[0] && lvl[0] == 2'h0;
  endsequence

  a_ext4_route_prio: assert property (@(posedge clk) disable iff (rst)
    (s_ext4_rise |=> status[0]) and
    (s_win0_cause |=> req.valid && req.num == 5'h00 &&
       req.vec_upper == 16'hfffa && req.vec_lower == 16'hfffb))
    else $error("request 0 routing or priority wrong");

  a_ext5_route_vec: assert property (@(posedge clk) disable iff (rst)
    $rose(src.ext_ch5) ##1 (enable[1] && lvl[1] == 2'h0 && !pending[0])
    |=> req.valid && req.num == 5'h01 &&
        req.vec_upper == 16'hfff8 && req.vec_lower == 16'hfff9)
    else $error("request 1 routing or vector wrong");

  a_ext26_merge: assert property (@(posedge clk) disable iff (rst)
    (s_ext26_rise |=> status[2]) and
    (req.valid && req.num == 5'h02 |->
       req.vec_upper == 16'hfff6 && req.vec_lower == 16'hfff7))
    else $error("request 2 merge or vector wrong");

  a_ext37_merge: assert property (@(posedge clk) disable iff (rst)
    (s_ext37_rise |=> status[3]) and
    (req.valid && req.num == 5'h03 |->
       req.vec_upper == 16'hfff4 && req.vec_lower == 16'hfff5))
    else $error("request 3 merge or vector wrong");

  a_tmr0_lo_route: assert property (@(posedge clk) disable iff (rst)
    ($rose(src.tmr0_lo) |=> status[5]) and
    (req.valid && req.num == 5'h05 |->
       req.vec_upper == 16'hfff0 && req.vec_lower == 16'hfff1))
    else $error("request 5 routing or vector wrong");

  a_tmr0_hi_route: assert property (@(posedge clk) disable iff (rst)
    ($rose(src.tmr0_hi) |=> status[6]) and
    (req.valid && req.num == 5'h06 |->
       req.vec_upper == 16'hffee && req.vec_lower == 16'hffef))
    else $error("request 6 routing or vector wrong");

  a_tmr1_hi_route: assert property (@(posedge clk) disable iff (rst)
    ($rose(src.tmr1_hi) |=> status[14]) and
    (req.valid && req.num == 5'h0e |->
       req.vec_upper == 16'hffde && req.vec_lower == 16'hffdf))
    else $error("request 14 routing or vector wrong");

  a_tmr1_lo_route: assert property (@(posedge clk) disable iff (rst)
    ($rose(src.tmr1_lo) |=> status[22]) and
    (req.valid && req.num == 5'h16 |->
       req.vec_upper == 16'hffce && req.vec_lower == 16'hffcf))
    else $error("request 22 routing or vector wrong");

  a_level5_reset: assert property (@(posedge clk)
    rst |=> ilr[5] == 8'hff && ilr[0] == 8'hff)
    else $error("level register not all ones after reset");

  a_misc_route_vec: assert property (@(posedge clk) disable iff (rst)
    ($rose(src.uart_rx) |=> status[7]) and
    ($rose(src.flash) |=> status[23]) and
    (req.valid && req.num == 5'h12 |-> req.vec_upper == 16'hffd6) and
    (req.valid && req.num == 5'h14 |-> req.vec_upper == 16'hffd2))
    else $error("serial, converter, watch or flash mapping wrong");

  a_unused_dead: assert property (@(posedge clk) disable iff (rst)
    (status & ~ivpm_pkg::REQ_USED) == 24'h000000 &&
    (!req.valid || ivpm_pkg::REQ_USED[req.num]))
    else $error("unassigned request became active");

  a_irq_level: assert property (@(posedge clk) disable iff (rst)
    irq == ((status & enable) != 24'h000000) &&
    (req.valid == $past(irq)))
    else $error("interrupt output disagrees with pending state");

endmodule

//--- tb/ivpm_cpu_model.sv
`timescale 1ns/1ns
// cpu core stand-in: takes the offered winner with a one-cycle ack
module ivpm_cpu_model (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire ivpm_pkg::ivpm_req_t req,
  input  wire logic                hold,
  input  wire logic                slow,
  output logic                     cpu_ack
);
  logic [2:0] wait_cnt;
  logic [2:0] seen_cnt;

  // after an ack, back off so the old winner can drain before a new look
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_ack  <= 1'b0;
      wait_cnt <= 3'h0;
      seen_cnt <= 3'h0;
    end else if (cpu_ack) begin
      cpu_ack  <= 1'b0;
      wait_cnt <= 3'h3;
      seen_cnt <= 3'h0;
    end else if (wait_cnt != 3'h0) begin
      wait_cnt <= wait_cnt - 3'h1;
    end else if (req.valid && !hold) begin
      // slow mode lets the request stand a few cycles first
      if (!slow || seen_cnt == 3'h3) begin
        cpu_ack <= 1'b1;
      end else begin
        seen_cnt <= seen_cnt + 3'h1;
      end
    end
  end
endmodule

//--- tb/tb.sv
`timescale 1ns/1ns
module tb;
  logic                clk;
  logic                rst;
  ivpm_pkg::ivpm_src_t src;
  logic                cpu_ack;
  ivpm_pkg::ivpm_req_t req;
  logic                irq;
  logic                hold;
  logic                slow;
  logic [11:0]         s_axi_awaddr;
  logic                s_axi_awvalid;
  logic                s_axi_awready;
  logic [31:0]         s_axi_wdata;
  logic [3:0]          s_axi_wstrb;
  logic                s_axi_wvalid;
  logic                s_axi_wready;
  logic [1:0]          s_axi_bresp;
  logic                s_axi_bvalid;
  logic                s_axi_bready;
  logic [11:0]         s_axi_araddr;
  logic                s_axi_arvalid;
  logic                s_axi_arready;
  logic [31:0]         s_axi_rdata;
  logic [1:0]          s_axi_rresp;
  logic                s_axi_rvalid;
  logic                s_axi_rready;
  int                  n_fail;
  int                  num_checks;
  // rows: source bit 15-i of src gives request row_num[i] at row_vec[i]
  localparam logic [4:0] row_num [16] = '{5'h02, 5'h03, 5'h00, 5'h01,
    5'h02, 5'h03, 5'h05, 5'h06, 5'h16, 5'h0e, 5'h07, 5'h08, 5'h12,
    5'h13, 5'h14, 5'h17};
  localparam logic [15:0] row_vec [16] = '{16'hfff6, 16'hfff4, 16'hfffa,
    16'hfff8, 16'hfff6, 16'hfff4, 16'hfff0, 16'hffee, 16'hffce, 16'hffde,
    16'hffec, 16'hffea, 16'hffd6, 16'hffd4, 16'hffd2, 16'hffcc};

  ivpm_top u_ivpm_top (.clk, .rst, .src, .cpu_ack, .req, .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  ivpm_cpu_model u_ivpm_cpu_model (.clk, .rst, .req, .hold, .slow,
    .cpu_ack);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ra;
    logic rw;
    logic bv;
    int   n;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      #1;
      ra = s_axi_awready;
      rw = s_axi_wready;
      bv = s_axi_bvalid;
      r  = s_axi_bresp;
      @(posedge clk);
      if (s_axi_awvalid && ra) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && rw) s_axi_wvalid <= 1'b0;
      if (bv) break;
    end
    if (n == 100) chk("write response", 32'h1, 32'h0);
    s_axi_bready <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ra;
    logic rv;
    int   n;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      #1;
      ra = s_axi_arready;
      rv = s_axi_rvalid;
      d  = s_axi_rdata;
      r  = s_axi_rresp;
      @(posedge clk);
      if (s_axi_arvalid && ra) s_axi_arvalid <= 1'b0;
      if (rv) break;
    end
    if (n == 100) chk("read response", 32'h1, 32'h0);
    s_axi_rready <= 1'b0;
    #1;
  endtask

  // one-cycle high level on the chosen sources makes a rising edge
  task automatic pulse(input logic [15:0] b);
    @(posedge clk);
    src <= ivpm_pkg::ivpm_src_t'(b);
    @(posedge clk);
    src <= ivpm_pkg::ivpm_src_t'(16'h0000);
  endtask

  task automatic wait_req(input logic v);
    int n;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      #1;
      if (req.valid === v) break;
    end
    if (n == 40) chk("req valid wait", {31'h0, v}, {31'h0, req.valid});
  endtask

  initial begin
    #(20000 * 50);
    n_fail++;
    close_out();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [23:0] all;
    logic [15:0] up;
    int          i;
    n_fail = 0;
    num_checks = 0;
    all = 24'h000000;
    rst = 1'b1;
    src = ivpm_pkg::ivpm_src_t'(16'h0000);
    hold = 1'b0;
    slow = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 12'h000;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // ordinary cases: each source alone, ack by the core model
    wr(12'h004, 32'h00ffffff, r);
    for (i = 0; i < 16; i++) begin
      slow <= i[0];
      pulse(16'h8000 >> i);
      wait_req(1'b1);
      up = row_vec[i];
      chk("req num", row_num[i], req.num);
      chk("vec upper", up, req.vec_upper);
      chk("vec lower", up + 16'h1, req.vec_lower);
      chk("req level", 32'h3, req.level);
      chk("irq raised", 32'h1, irq);
      wait_req(1'b0);
      chk("irq dropped", 32'h0, irq);
      all = all | (24'h000001 << row_num[i]);
    end
    $display("test source map done");
    // register reset values, access kinds and refusals
    rd(12'h1f8, d, r);
    chk("level5 value", 32'hff, d);
    rd(12'h1e4, d, r);
    chk("level0 value", 32'hff, d);
    wr(12'h1f8, 32'h5a, r);
    rd(12'h1f8, d, r);
    chk("level5 readback", 32'h5a, d);
    rd(12'h100, d, r);
    chk("unmapped resp", ivpm_pkg::RESP_SLVERR, r);
    chk("unmapped data", 32'h0, d);
    wr(12'h000, 32'hffffffff, r);
    chk("status write resp", ivpm_pkg::RESP_SLVERR, r);
    $display("test registers done");
    // tie between first and last request, then level reorders them
    hold <= 1'b1;
    // requests 0 and 1 at the top level: 1 alone, then 0 arrives and wins
    wr(12'h1e4, 32'hf0, r);
    chk("level0 write resp", ivpm_pkg::RESP_OKAY, r);
    pulse(16'h1000);
    wait_req(1'b1);
    chk("top level winner", 32'h1, req.num);
    pulse(16'h2000);
    repeat (2) @(posedge clk);
    #1;
    chk("top level preempt", 32'h0, req.num);
    chk("top level value", 32'h0, req.level);
    wr(12'h1e4, 32'hff, r);
    wr(12'h1f8, 32'hff, r);
    pulse(16'h2001);
    wait_req(1'b1);
    chk("tie winner", 32'h0, req.num);
    wr(12'h1f8, 32'h3f, r);
    rd(12'h00c, d, r);
    chk("winner reg", 32'h97, d);
    chk("level winner", 32'h17, req.num);
    chk("level value", 32'h0, req.level);
    wr(12'h1f8, 32'hff, r);
    $display("test priority done");
    // every source at once: only wired requests may pend
    pulse(16'hffff);
    rd(12'h000, d, r);
    chk("status all", {8'h00, all}, d);
    wr(12'h004, 32'h0, r);
    chk("irq masked", 32'h0, irq);
    wr(12'h004, 32'h00800000, r);
    chk("irq enabled", 32'h1, irq);
    wr(12'h008, 32'h00800000, r);
    chk("irq cleared", 32'h0, irq);
    rd(12'h008, d, r);
    chk("clear reads zero", 32'h0, d);
    rd(12'h000, d, r);
    chk("status partial", {8'h00, all & 24'h7fffff}, d);
    wr(12'h008, 32'h00ffffff, r);
    wr(12'h004, 32'h00ffffff, r);
    rd(12'h000, d, r);
    chk("status empty", 32'h0, d);
    hold <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("no winner", 32'h0, req.valid);
    chk("irq idle", 32'h0, irq);
    $display("test all sources done");
    // mid-run reset with a request pending and a level changed
    hold <= 1'b1;
    wr(12'h1f8, 32'h00, r);
    pulse(16'h0001);
    wait_req(1'b1);
    chk("irq before reset", 32'h1, irq);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("reset winner", 32'h0, req.valid);
    chk("reset irq", 32'h0, irq);
    rd(12'h004, d, r);
    chk("reset enable", 32'h0, d);
    rd(12'h1f8, d, r);
    chk("reset level5", 32'hff, d);
    rd(12'h000, d, r);
    chk("reset status", 32'h0, d);
    $display("test reset done");
    close_out();
  end
endmodule
